// ### src/osp_sync_pins.sv
// turn-on and turn-off sync pins with their axi4-lite register slave
// What this block does
// - turn-on pin sends and receives pulses
// - pulses hold low at least 30 us
// - local turn-on emits pulse on on-pin
// - on-pin pulse while on changes nothing
// - on-pin pulse while off turns on
// - turn-off pin bidirectional, its default mode
// - local turn-off emits pulse on off-pin
// - off-pin pulse while off changes nothing
// - off-pin pulse while on turns off
// - invert setting flips input and output sense
// - input mode samples pin as level
// - output mode drives one, zero or pwm
// - logic one: low, high when inverted
// - logic zero: high, low when inverted
// - partner turns on with our on-pulse
// - partner turns off with our off-pulse
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`include "osp_defines.svh"
`default_nettype none

// ----------------------------------------
// one pin: synchroniser, pulse tx/rx, pwm
// ----------------------------------------
module osp_pin
	import osp_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // sync reset, high
	input var osp_pin_cfg_t cfg, // pin configuration
	input wire logic fire, // request a sync pulse
	input wire logic pin_i, // pin level in
	output logic pin_o, // pin level out
	output logic pin_oe, // pin driven
	output logic level, // logical input level
	output logic rx_pulse, // qualified received pulse
	output logic tx_busy // sync pulse being sent
);
	logic s1_reg, s2_reg, s3_reg, stab_reg;
	logic [`OSP_CNT_W-1:0] tx_cnt_reg, low_cnt_reg;
	logic [3:0] blank_reg;
	logic [15:0] pwm_cnt_reg;
	logic pwm_val, ignore, sync_mode;

	assign sync_mode = (cfg.mode == OSP_MODE_SYNC);
	assign tx_busy = (tx_cnt_reg != '0);
	assign level = ~stab_reg ^ cfg.inv;
	assign pwm_val = (pwm_cnt_reg < cfg.duty);
	assign ignore = tx_busy || (blank_reg != 4'h0) || !sync_mode;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			stab_reg <= 1'b1;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				stab_reg <= s3_reg;
			end
		end
	end

	// sync pulse length counter
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_cnt_reg <= '0;
		end else if (fire && !tx_busy && sync_mode) begin
			tx_cnt_reg <= `OSP_CNT_W'(`OSP_PULSE_CYC);
		end else if (tx_busy) begin
			tx_cnt_reg <= tx_cnt_reg - `OSP_CNT_W'(1);
		end
	end

	// hides our own pulse until the synchroniser has seen it go
	always_ff @(posedge clk) begin
		if (rst) begin
			blank_reg <= 4'h0;
		end else if (tx_busy || pin_oe) begin
			blank_reg <= `OSP_BLANK_CYC;
		end else if (blank_reg != 4'h0) begin
			blank_reg <= blank_reg - 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || ignore || !level) begin
			low_cnt_reg <= '0;
			rx_pulse <= 1'b0;
		end else if (low_cnt_reg != `OSP_CNT_W'(`OSP_PULSE_CYC)) begin
			low_cnt_reg <= low_cnt_reg + `OSP_CNT_W'(1);
			rx_pulse <= (low_cnt_reg == `OSP_CNT_W'(`OSP_PULSE_CYC - 1));
		end else begin
			rx_pulse <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || cfg.mode != OSP_MODE_OUTPUT) begin
			pwm_cnt_reg <= 16'h0000;
		end else if ({1'b0, pwm_cnt_reg} + 17'h00001 >= {1'b0, cfg.period}) begin
			pwm_cnt_reg <= 16'h0000;
		end else begin
			pwm_cnt_reg <= pwm_cnt_reg + 16'h0001;
		end
	end

	// logic one is a low pin unless inverted
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_o <= 1'b1;
			pin_oe <= 1'b0;
		end else begin
			unique case (cfg.mode)
				OSP_MODE_SYNC: begin
					pin_oe <= tx_busy;
					pin_o <= cfg.inv;
				end
				OSP_MODE_INPUT: begin
					pin_oe <= 1'b0;
					pin_o <= 1'b1;
				end
				OSP_MODE_OUTPUT: begin
					pin_oe <= 1'b1;
					unique case (cfg.sel)
						OSP_SEL_ONE: pin_o <= cfg.inv;
						OSP_SEL_PWM: pin_o <= ~(pwm_val ^ cfg.inv);
						default: pin_o <= ~cfg.inv;
					endcase
				end
				default: begin
					pin_oe <= 1'b0;
					pin_o <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [`OSP_CNT_W-1:0] oe_run_reg, as_run_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			oe_run_reg <= '0;
			as_run_reg <= '0;
		end else begin
			oe_run_reg <= pin_oe ? oe_run_reg + `OSP_CNT_W'(1) : '0;
			as_run_reg <= (level && !ignore) ? as_run_reg + `OSP_CNT_W'(1) : '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_sync_idle;
		(sync_mode && !tx_busy)[*2];
	endsequence
	sequence s_tx_end;
		tx_busy ##1 !tx_busy;
	endsequence

	property p_tx_width;
		$fell(pin_oe) && sync_mode && $past(sync_mode) && $past(sync_mode, 2) |->
			oe_run_reg == `OSP_CNT_W'(`OSP_PULSE_CYC);
	endproperty
	a_tx_width: assert property (p_tx_width) else $error("sync pulse width wrong");
	property p_rx_qual;
		rx_pulse |-> as_run_reg >= `OSP_CNT_W'(`OSP_PULSE_CYC);
	endproperty
	a_rx_qual: assert property (p_rx_qual) else $error("pulse taken too short");
	property p_no_self;
		s_tx_end |-> (!rx_pulse)[*8];
	endproperty
	a_no_self: assert property (p_no_self) else $error("own pulse received");
	property p_sync_release;
		s_sync_idle |-> !pin_oe;
	endproperty
	a_sync_release: assert property (p_sync_release) else $error("pin held outside pulse");
	property p_drive_one;
		(cfg.mode == OSP_MODE_OUTPUT && cfg.sel == OSP_SEL_ONE)[*2] |->
			pin_oe && pin_o == $past(cfg.inv);
	endproperty
	a_drive_one: assert property (p_drive_one) else $error("logic one level wrong");
	property p_drive_zero;
		(cfg.mode == OSP_MODE_OUTPUT && cfg.sel == OSP_SEL_ZERO)[*2] |->
			pin_oe && pin_o != $past(cfg.inv);
	endproperty
	a_drive_zero: assert property (p_drive_zero) else $error("logic zero level wrong");
	property p_input;
		(cfg.mode == OSP_MODE_INPUT)[*2] |-> !pin_oe;
	endproperty
	a_input: assert property (p_input) else $error("input mode drives pin");
	property p_pwm;
		(cfg.mode == OSP_MODE_OUTPUT && cfg.sel == OSP_SEL_PWM)[*2] |->
			pin_o == ~($past(pwm_val) ^ $past(cfg.inv));
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm level wrong");
endmodule

// ----------------------------------------
// top: output state, two pins, register slave
// ----------------------------------------
module osp_sync_pins
	import osp_pkg::*;
(
	input wire logic SYS_CLK, // 100 MHz clock
	input wire logic SYS_RST, // sync reset, high
	input wire logic [7:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // byte enables
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [7:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	input wire logic KEY_PRESS, // local on/off key pulse
	output logic OUT_ENABLE, // output on
	input wire logic PIN_ON_I, // turn-on pin in
	output logic PIN_ON_O, // turn-on pin out
	output logic PIN_ON_OE, // turn-on pin driven
	input wire logic PIN_OFF_I, // turn-off pin in
	output logic PIN_OFF_O, // turn-off pin out
	output logic PIN_OFF_OE // turn-off pin driven
);
	logic [31:0] ctrl_reg;
	logic [15:0] on_per_reg, on_duty_reg, off_per_reg, off_duty_reg;
	logic fire_on_reg, fire_off_reg;
	logic aw_full_reg, w_full_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	osp_pin_cfg_t cfg_on, cfg_off;
	logic on_rx, off_rx, on_lvl, off_lvl, on_tx, off_tx;
	logic [7:0] on_c, off_c;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	assign on_c = ctrl_reg[`OSP_CTRL_ON_LSB +: 8];
	assign off_c = ctrl_reg[`OSP_CTRL_OFF_LSB +: 8];
	assign cfg_on = '{mode: osp_mode_t'(on_c[`OSP_F_MODE_LSB +: 2]), inv: on_c[`OSP_F_INV],
		sel: osp_sel_t'(on_c[`OSP_F_SEL_LSB +: 2]), period: on_per_reg, duty: on_duty_reg};
	assign cfg_off = '{mode: osp_mode_t'(off_c[`OSP_F_MODE_LSB +: 2]), inv: off_c[`OSP_F_INV],
		sel: osp_sel_t'(off_c[`OSP_F_SEL_LSB +: 2]), period: off_per_reg, duty: off_duty_reg};

	osp_pin u_on (.clk(SYS_CLK), .rst(SYS_RST), .cfg(cfg_on), .fire(fire_on_reg),
		.pin_i(PIN_ON_I), .pin_o(PIN_ON_O), .pin_oe(PIN_ON_OE), .level(on_lvl),
		.rx_pulse(on_rx), .tx_busy(on_tx));
	osp_pin u_off (.clk(SYS_CLK), .rst(SYS_RST), .cfg(cfg_off), .fire(fire_off_reg),
		.pin_i(PIN_OFF_I), .pin_o(PIN_OFF_O), .pin_oe(PIN_OFF_OE), .level(off_lvl),
		.rx_pulse(off_rx), .tx_busy(off_tx));

	// ----------------------------------------
	// output state; a local key wins over a received pulse
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			OUT_ENABLE <= 1'b0;
			fire_on_reg <= 1'b0;
			fire_off_reg <= 1'b0;
		end else begin
			fire_on_reg <= KEY_PRESS && !OUT_ENABLE;
			fire_off_reg <= KEY_PRESS && OUT_ENABLE;
			if (KEY_PRESS) begin
				OUT_ENABLE <= !OUT_ENABLE;
			end else if (off_rx && OUT_ENABLE) begin
				OUT_ENABLE <= 1'b0;
			end else if (on_rx && !OUT_ENABLE) begin
				OUT_ENABLE <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				S_AXI_AWREADY <= 1'b0;
				aw_full_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				S_AXI_WREADY <= 1'b0;
				w_full_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `OSP_RESP_OKAY;
			ctrl_reg <= `OSP_CTRL_RST;
			on_per_reg <= `OSP_PER_RST;
			on_duty_reg <= `OSP_DUTY_RST;
			off_per_reg <= `OSP_PER_RST;
			off_duty_reg <= `OSP_DUTY_RST;
		end else if (S_AXI_BVALID) begin
			if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end else if (aw_full_reg && w_full_reg) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= `OSP_RESP_OKAY;
			unique case (awaddr_reg)
				`OSP_ADDR_CTRL:
					ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & `OSP_CTRL_MASK;
				`OSP_ADDR_STATUS: ;
				`OSP_ADDR_ON_PER:
					on_per_reg <= 16'(merge({16'h0000, on_per_reg}, wdata_reg, wstrb_reg));
				`OSP_ADDR_ON_DUTY:
					on_duty_reg <= 16'(merge({16'h0000, on_duty_reg}, wdata_reg, wstrb_reg));
				`OSP_ADDR_OFF_PER:
					off_per_reg <= 16'(merge({16'h0000, off_per_reg}, wdata_reg, wstrb_reg));
				`OSP_ADDR_OFF_DUTY:
					off_duty_reg <= 16'(merge({16'h0000, off_duty_reg}, wdata_reg, wstrb_reg));
				default: S_AXI_BRESP <= `OSP_RESP_SLVERR;
			endcase
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `OSP_RESP_OKAY;
		end else if (S_AXI_RVALID) begin
			if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= `OSP_RESP_OKAY;
			S_AXI_RDATA <= 32'h00000000;
			unique case (S_AXI_ARADDR)
				`OSP_ADDR_CTRL: S_AXI_RDATA <= ctrl_reg;
				`OSP_ADDR_STATUS: begin
					S_AXI_RDATA[`OSP_ST_OUT] <= OUT_ENABLE;
					S_AXI_RDATA[`OSP_ST_ON_LVL] <= on_lvl;
					S_AXI_RDATA[`OSP_ST_OFF_LVL] <= off_lvl;
					S_AXI_RDATA[`OSP_ST_ON_TX] <= on_tx;
					S_AXI_RDATA[`OSP_ST_OFF_TX] <= off_tx;
				end
				`OSP_ADDR_ON_PER: S_AXI_RDATA[15:0] <= on_per_reg;
				`OSP_ADDR_ON_DUTY: S_AXI_RDATA[15:0] <= on_duty_reg;
				`OSP_ADDR_OFF_PER: S_AXI_RDATA[15:0] <= off_per_reg;
				`OSP_ADDR_OFF_DUTY: S_AXI_RDATA[15:0] <= off_duty_reg;
				default: S_AXI_RRESP <= `OSP_RESP_SLVERR;
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cbt @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_key_on;
		KEY_PRESS && !OUT_ENABLE && cfg_on.mode == OSP_MODE_SYNC && !on_tx;
	endsequence
	sequence s_key_off;
		KEY_PRESS && OUT_ENABLE && cfg_off.mode == OSP_MODE_SYNC && !off_tx;
	endsequence

	property p_key_on;
		s_key_on |-> ##1 OUT_ENABLE ##2 PIN_ON_OE;
	endproperty
	a_key_on: assert property (p_key_on) else $error("no pulse on turn-on");
	property p_key_off;
		s_key_off |-> ##1 !OUT_ENABLE ##2 PIN_OFF_OE;
	endproperty
	a_key_off: assert property (p_key_off) else $error("no pulse on turn-off");
	property p_rx_on;
		on_rx && !OUT_ENABLE && !KEY_PRESS |=> OUT_ENABLE;
	endproperty
	a_rx_on: assert property (p_rx_on) else $error("on pulse ignored");
	property p_rx_on_keep;
		on_rx && OUT_ENABLE && !KEY_PRESS && !off_rx |=> OUT_ENABLE;
	endproperty
	a_rx_on_keep: assert property (p_rx_on_keep) else $error("on pulse changed state");
	property p_rx_off;
		off_rx && OUT_ENABLE && !KEY_PRESS |=> !OUT_ENABLE;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("off pulse ignored");
	property p_rx_off_keep;
		off_rx && !OUT_ENABLE && !KEY_PRESS && !on_rx |=> !OUT_ENABLE;
	endproperty
	a_rx_off_keep: assert property (p_rx_off_keep) else $error("off pulse changed state");
	property p_wr_resp;
		aw_full_reg && w_full_reg && !S_AXI_BVALID |=> S_AXI_BVALID;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
endmodule
`default_nettype wire

// ### src/osp_defines.svh
// offsets, field positions, reset values and timing counts for the sync pins
`ifndef OSP_DEFINES_SVH
`define OSP_DEFINES_SVH

`define OSP_ADDR_CTRL 8'h00
`define OSP_ADDR_STATUS 8'h04
`define OSP_ADDR_ON_PER 8'h08
`define OSP_ADDR_ON_DUTY 8'h0C
`define OSP_ADDR_OFF_PER 8'h10
`define OSP_ADDR_OFF_DUTY 8'h14

`define OSP_CTRL_ON_LSB 0
`define OSP_CTRL_OFF_LSB 8
`define OSP_F_MODE_LSB 0
`define OSP_F_INV 2
`define OSP_F_SEL_LSB 3
`define OSP_CTRL_MASK 32'h00001F1F
`define OSP_CTRL_RST 32'h00000000
`define OSP_PER_RST 16'h0064
`define OSP_DUTY_RST 16'h0032

`define OSP_ST_OUT 0
`define OSP_ST_ON_LVL 1
`define OSP_ST_OFF_LVL 2
`define OSP_ST_ON_TX 3
`define OSP_ST_OFF_TX 4

`define OSP_RESP_OKAY 2'h0
`define OSP_RESP_SLVERR 2'h2

`define OSP_CLK_NS 10
`define OSP_PULSE_NS 30000
`define OSP_PULSE_CYC ((`OSP_PULSE_NS + `OSP_CLK_NS - 1) / `OSP_CLK_NS)
`define OSP_CNT_W 12
`define OSP_BLANK_CYC 4'h8

`endif

// ### src/osp_pkg.sv
// types shared by the sync pin logic
`default_nettype none
package osp_pkg;
	typedef enum logic [1:0] {OSP_MODE_SYNC, OSP_MODE_INPUT, OSP_MODE_OUTPUT} osp_mode_t;
	typedef enum logic [1:0] {OSP_SEL_ZERO, OSP_SEL_ONE, OSP_SEL_PWM} osp_sel_t;
	typedef struct packed {
		osp_mode_t mode;
		logic inv;
		osp_sel_t sel;
		logic [15:0] period;
		logic [15:0] duty;
	} osp_pin_cfg_t;
endpackage
`default_nettype wire

// ### sim/osp_partner.sv
// model of the matching sync pin on a second instrument
`include "osp_defines.svh"
`default_nettype none

// ----------------------------------------
// partner pin: pulse sender and receiver
// ----------------------------------------
module osp_partner (
	input wire logic clk, // system clock
	input wire logic rst, // sync reset, high
	input wire logic send, // start one low pulse
	input wire logic [15:0] len, // pulse low time, cycles
	input wire logic line, // resolved pin level
	output logic drive_val, // level driven while active
	output logic drive_en, // pin driven
	output logic [7:0] rx_cnt // pulses recognised
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] tx_left_reg;
	logic [15:0] low_cnt_reg;
	assign drive_val = 1'h0;
	assign drive_en = tx_left_reg != 16'h0;
	// low for the commanded time, then release to the pull-up
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_left_reg <= 16'h0;
		end else if (send) begin
			tx_left_reg <= len;
		end else if (tx_left_reg != 16'h0) begin
			tx_left_reg <= tx_left_reg - 16'h1;
		end
	end
	// own pulse is not counted; one count per long enough low
	always_ff @(posedge clk) begin
		if (rst || line || drive_en) begin
			low_cnt_reg <= 16'h0;
		end else if (low_cnt_reg != 16'(`OSP_PULSE_CYC)) begin
			low_cnt_reg <= low_cnt_reg + 16'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_cnt <= 8'h0;
		end else if (low_cnt_reg == 16'(`OSP_PULSE_CYC - 1) && !line && !drive_en) begin
			rx_cnt <= rx_cnt + 8'h1;
		end
	end
endmodule
`default_nettype wire

// ### sim/test_osp_sync_pins.sv
// self-checking bench for the turn-on and turn-off sync pins
`include "osp_defines.svh"
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
	$display("wrong value at %0t got %h exp %h", $time, (got), (exp)); end end

module test_osp_sync_pins;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, key, en;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic on_o, on_oe, off_o, off_oe, on_line, off_line;
	logic p_on_val, p_on_en, p_off_val, p_off_en, p_on_go, p_off_go;
	logic [15:0] p_len;
	logic [7:0] p_on_cnt, p_off_cnt;
	int errors, num_checks;

	// pins resolve with a pull-up when nobody drives
	assign on_line = (on_oe ? on_o : 1'h1) & (p_on_en ? p_on_val : 1'h1);
	assign off_line = (off_oe ? off_o : 1'h1) & (p_off_en ? p_off_val : 1'h1);

	osp_sync_pins osp_sync_pins_inst (.SYS_CLK(clk), .SYS_RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.KEY_PRESS(key), .OUT_ENABLE(en),
		.PIN_ON_I(on_line), .PIN_ON_O(on_o), .PIN_ON_OE(on_oe),
		.PIN_OFF_I(off_line), .PIN_OFF_O(off_o), .PIN_OFF_OE(off_oe));
	osp_partner partner_on (.clk(clk), .rst(rst), .send(p_on_go), .len(p_len), .line(on_line),
		.drive_val(p_on_val), .drive_en(p_on_en), .rx_cnt(p_on_cnt));
	osp_partner partner_off (.clk(clk), .rst(rst), .send(p_off_go), .len(p_len),
		.line(off_line), .drive_val(p_off_val), .drive_en(p_off_en), .rx_cnt(p_off_cnt));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// bus, key and partner tasks
	// ----------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				aw_done = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready) begin
				w_done = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		`CHK(bresp, r)
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge clk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		d = rdata;
		`CHK(rresp, r)
	endtask

	task automatic press;
		key <= 1'h1;
		@(posedge clk);
		key <= 1'h0;
	endtask

	// waits for a pulse on one pin and measures its driven length
	task automatic pulse_len(input bit off_pin, output int n, output logic lvl);
		int w;
		n = 0;
		w = 0;
		while ((off_pin ? off_oe : on_oe) !== 1'h1 && w < 20) begin
			@(posedge clk);
			w++;
		end
		lvl = off_pin ? off_o : on_o;
		while ((off_pin ? off_oe : on_oe) === 1'h1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic send(input bit off_pin, input int len, input int hold);
		p_len <= 16'(len);
		p_on_go <= !off_pin;
		p_off_go <= off_pin;
		@(posedge clk);
		p_on_go <= 1'h0;
		p_off_go <= 1'h0;
		repeat (hold) @(posedge clk);
	endtask

	task automatic count_low(output int n);
		n = 0;
		repeat (100) begin
			@(posedge clk);
			if (on_line === 1'h0) n++;
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		int n;
		logic lvl;
		logic [31:0] d;
		logic [7:0] c_on, c_off;
		errors = 0;
		num_checks = 0;
		rst = 1'h1;
		key = 1'h0;
		awvalid = 1'h0;
		wvalid = 1'h0;
		bready = 1'h0;
		arvalid = 1'h0;
		rready = 1'h0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		p_len = 16'h0;
		p_on_go = 1'h0;
		p_off_go = 1'h0;
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		axi_rd(`OSP_ADDR_CTRL, d, `OSP_RESP_OKAY);
		`CHK(d, `OSP_CTRL_RST)
		axi_rd(`OSP_ADDR_ON_PER, d, `OSP_RESP_OKAY);
		`CHK(d, {16'h0, `OSP_PER_RST})
		axi_rd(`OSP_ADDR_OFF_DUTY, d, `OSP_RESP_OKAY);
		`CHK(d, {16'h0, `OSP_DUTY_RST})
		axi_rd(8'h18, d, `OSP_RESP_SLVERR);
		axi_wr(8'h18, 32'hFFFFFFFF, `OSP_RESP_SLVERR);
		axi_wr(`OSP_ADDR_CTRL, 32'hFFFFFFFF, `OSP_RESP_OKAY);
		axi_rd(`OSP_ADDR_CTRL, d, `OSP_RESP_OKAY);
		`CHK(d, `OSP_CTRL_MASK)
		axi_wr(`OSP_ADDR_CTRL, `OSP_CTRL_RST, `OSP_RESP_OKAY);
		repeat (20) @(posedge clk);
		c_on = p_on_cnt;
		c_off = p_off_cnt;
		press();
		pulse_len(1'h0, n, lvl);
		`CHK(en, 1'h1)
		`CHK(n, `OSP_PULSE_CYC)
		`CHK(lvl, 1'h0)
		`CHK(off_oe, 1'h0)
		repeat (20) @(posedge clk);
		`CHK(p_on_cnt, c_on + 8'h1)
		`CHK(en, 1'h1)
		send(1'h0, 3000, 3040);
		`CHK(en, 1'h1)
		press();
		pulse_len(1'h1, n, lvl);
		`CHK(en, 1'h0)
		`CHK(n, `OSP_PULSE_CYC)
		`CHK(lvl, 1'h0)
		repeat (20) @(posedge clk);
		`CHK(p_off_cnt, c_off + 8'h1)
		send(1'h1, 3000, 3040);
		`CHK(en, 1'h0)
		send(1'h0, 2995, 3040);
		`CHK(en, 1'h0)
		send(1'h0, 3000, 3040);
		`CHK(en, 1'h1)
		`CHK(p_on_cnt, c_on + 8'h1)
		send(1'h1, 3000, 3040);
		`CHK(en, 1'h0)
		for (int i = 0; i < 4; i++) begin
			axi_wr(`OSP_ADDR_CTRL, 32'(2 + 4 * (i % 2) + 8 * (i / 2)), `OSP_RESP_OKAY);
			repeat (3) @(posedge clk);
			`CHK(on_oe, 1'h1)
			`CHK(on_line, 1'(i % 2) ^ ~1'(i / 2))
		end
		axi_wr(`OSP_ADDR_ON_PER, 32'hA, `OSP_RESP_OKAY);
		axi_wr(`OSP_ADDR_ON_DUTY, 32'h4, `OSP_RESP_OKAY);
		axi_wr(`OSP_ADDR_CTRL, 32'h12, `OSP_RESP_OKAY);
		count_low(n);
		`CHK(n, 40)
		axi_wr(`OSP_ADDR_CTRL, 32'h16, `OSP_RESP_OKAY);
		count_low(n);
		`CHK(n, 60)
		axi_wr(`OSP_ADDR_CTRL, 32'h100, `OSP_RESP_OKAY);
		repeat (3) @(posedge clk);
		`CHK(off_oe, 1'h0)
		axi_rd(`OSP_ADDR_STATUS, d, `OSP_RESP_OKAY);
		`CHK(d[2], 1'h0)
		send(1'h1, 500, 10);
		axi_rd(`OSP_ADDR_STATUS, d, `OSP_RESP_OKAY);
		`CHK(d[2], 1'h1)
		axi_wr(`OSP_ADDR_CTRL, 32'h500, `OSP_RESP_OKAY);
		repeat (5) @(posedge clk);
		axi_rd(`OSP_ADDR_STATUS, d, `OSP_RESP_OKAY);
		`CHK(d[2], 1'h0)
		close_out();
	end

	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
